/* design/tscac_pkg.sv */
/*
 constants, field layouts and types for the temperature sensor
 conversion and alarm control core.
 assumes an i2c byte framing layer beside the core and an analog front end
 that delivers a signed reading in sixteenths of a degree.
*/
// Overview of operation
// RL1: thresholds share result format; hysteresis capped at limit
// RL2: one-shot in shutdown, self-clears, returns to shutdown
// RL3: bit 4 low enables clock-low bus timeout
// RL4: bit 7 selects normal or extended format
// RL5: result keeps old format until next conversion
// RL6: master writes thresholds in current format
// RL7: rate bits pick 4, 1, 0.25, 0.125 s periods
// RL8: idle between automatic conversions at low power
// RL9: resolution bits pick 8, 9, 10, 12 bits
// RL10: conversion 35 ms at 10 bits, doubling per bit
// RL11: shutdown waits for running conversion to finish
// RL12: registers stay accessible during shutdown
// RL13: clearing shutdown starts continuous conversion at once
// RL14: fault queue needs 1, 2, 4, 6 results
// RL15: hysteresis clear ignores fault queue
// RL16: bit 15 is read-only overtemp flag
// RL17: comparator mode sets above limit, clears below hysteresis
// RL18: interrupt mode flag cleared by any read
// RL19: interrupt mode alternates rising and falling sets
// RL20: shutdown entry clears flag in interrupt mode too
// RL21: crc-8 check byte over whole message when enabled
// RL22: power-on values 0040h, 4b00h, 5000h
// RL23: single data byte lands in upper byte
// RL24: pointer never auto-increments
// RL25: result updates only on conversion completion
// RL26: consecutive over count resets on non-over result
package tscac_pkg;
    localparam logic [7:0] PTR_TEMP = 8'h00;
    localparam logic [7:0] PTR_CFG = 8'h01;
    localparam logic [7:0] PTR_HYST = 8'h02;
    localparam logic [7:0] PTR_OS = 8'h03;

    localparam logic [15:0] TEMP_RST = 16'h0000;
    localparam logic [15:0] CFG_RST = 16'h0040;
    localparam logic [15:0] HYST_RST = 16'h4b00;
    localparam logic [15:0] OS_RST = 16'h5000;
    localparam logic [15:0] CFG_WR_MASK = 16'h1bfe;

    localparam int CLK_MHZ = 50;
    localparam int TIMEOUT_US = 30000;
    localparam int CONV10_US = 35000;
    localparam int RATE_BASE_US = 125000;
    localparam int CONV_QTR_DIV = 4;
    localparam int CONV_QTR [4] = '{1, 2, 4, 16};
    localparam int RATE_MULT [4] = '{32, 8, 2, 1};

    localparam logic [2:0] FAULT_NEED [4] = '{3'h1, 3'h2, 3'h4, 3'h6};
    localparam logic [2:0] FAULT_SAT = 3'h7;
    localparam logic [3:0] RES_FRAC [4] = '{4'h0, 4'h1, 4'h2, 4'h4};
    localparam logic [3:0] LSB_NORMAL = 4'h8;
    localparam logic [3:0] LSB_EXT = 4'h7;

    localparam int TEMP_W = 13;
    localparam logic signed [12:0] NORM_MAX = 13'sh07ff;
    localparam logic signed [12:0] NORM_MIN = 13'sh1800;

    localparam logic [7:0] CRC_POLY = 8'h07;

    typedef struct packed {
        logic ot;
        logic [1:0] rsv_hi;
        logic [1:0] fault;
        logic rsv_mid;
        logic intr;
        logic sd;
        logic fmt;
        logic [1:0] res;
        logic tmo_dis;
        logic pec;
        logic [1:0] rate;
        logic one;
    } tscac_cfg_t;

    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
        logic has_hi;
        logic has_lo;
    } tscac_stage_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01,
        ST_WAIT = 2'b10
    } tscac_state_t;
endpackage

/* design/tscac_core.sv */
/*
 register file, conversion sequencer, overtemperature flag, crc and
 bus timeout of the temperature sensor.
 assumes an i2c framing layer on clk_i that reports start, stop, pointer,
 data bytes and every bus byte, and fetches read bytes one at a time.
*/
`timescale 1ns/1ps
module tscac_core #(
    parameter int TIMEOUT_CYC = tscac_pkg::TIMEOUT_US * tscac_pkg::CLK_MHZ,
    parameter int CONV10_CYC = tscac_pkg::CONV10_US * tscac_pkg::CLK_MHZ,
    parameter int RATE_BASE_CYC = tscac_pkg::RATE_BASE_US * tscac_pkg::CLK_MHZ
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic msg_start_i,
    input wire logic msg_stop_i,
    input wire logic bus_byte_valid_i,
    input wire logic [7:0] bus_byte_i,
    input wire logic ptr_wr_i,
    input wire logic [7:0] ptr_i,
    input wire logic wr_byte_valid_i,
    input wire logic [7:0] wr_byte_i,
    input wire logic rd_req_i,
    input wire logic signed [tscac_pkg::TEMP_W-1:0] temp_raw_i,
    output logic [7:0] rd_data_o,
    output logic rd_valid_o,
    output logic [7:0] pec_o,
    output logic bus_reset_o,
    output logic conv_active_o,
    output logic overtemp_o
);
    if (TIMEOUT_CYC < 1 || CONV10_CYC < 4 || RATE_BASE_CYC < 1 ||
        RATE_BASE_CYC > 67108863 || CONV10_CYC > 268435455) begin : g_chk
        $error("tscac_core: timing parameter out of range");
    end

    localparam logic [31:0] TMO_C = 32'(TIMEOUT_CYC);

    logic scl_meta_reg, scl_sync_reg;
    logic [31:0] low_cnt_reg;
    logic bus_reset_reg;
    logic [7:0] crc_reg;
    logic [7:0] ptr_reg;
    tscac_pkg::tscac_stage_t stage_reg, prev_reg, use_stg;
    logic wr_tog_reg, rd_tog_reg;
    tscac_pkg::tscac_cfg_t cfg_reg, wr_cfg, cfg_rd;
    logic [15:0] hyst_reg, os_reg, result_reg;
    tscac_pkg::tscac_state_t state_reg;
    logic [31:0] t_reg, conv_len, period;
    logic shot_reg;
    logic [2:0] fault_cnt_reg;
    logic flag_reg, arm_low_reg;
    logic [7:0] rd_data_reg;
    logic rd_valid_reg;
    logic commit, cfg_wr, done, wrap, sd_enter, over, over_q, under;
    logic [15:0] cur_word, wr_word, rd_word, res_next, eff_hyst, mask;
    logic signed [12:0] t_clamp;
    logic [3:0] lsb;

    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] x;
        x = c ^ d;
        for (int i = 0; i < 8; i++) begin
            x = x[7] ? ((x << 1) ^ tscac_pkg::CRC_POLY) : (x << 1);
        end
        return x;
    endfunction

    // clock line synchroniser
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_meta_reg <= 1'b1;
            scl_sync_reg <= 1'b1;
        end else begin
            scl_meta_reg <= scl_i;
            scl_sync_reg <= scl_meta_reg;
        end
    end

    // clock-low timeout
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            low_cnt_reg <= 32'h0000_0000;
            bus_reset_reg <= 1'b0;
        end else begin
            bus_reset_reg <= 1'b0;
            if (scl_sync_reg || cfg_reg.tmo_dis) begin // [RL3]
                low_cnt_reg <= 32'h0000_0000;
            end else if (low_cnt_reg != TMO_C) begin
                low_cnt_reg <= low_cnt_reg + 32'h0000_0001;
                bus_reset_reg <= (low_cnt_reg == TMO_C - 32'h0000_0001); // [RL3]
            end
        end
    end

    // packet error code over every bus byte
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            crc_reg <= 8'h00;
        end else if (bus_byte_valid_i) begin
            crc_reg <= crc8(msg_start_i ? 8'h00 : crc_reg, bus_byte_i); // [RL21]
        end else if (msg_start_i) begin
            crc_reg <= 8'h00;
        end
    end

    // pointer, write staging and read byte select
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ptr_reg <= tscac_pkg::PTR_TEMP;
            stage_reg <= '0;
            prev_reg <= '0;
            wr_tog_reg <= 1'b0;
            rd_tog_reg <= 1'b0;
        end else if (msg_start_i || msg_stop_i || bus_reset_reg || ptr_wr_i) begin
            if (ptr_wr_i && !bus_reset_reg) begin
                ptr_reg <= ptr_i;
            end
            stage_reg <= '0;
            prev_reg <= '0;
            wr_tog_reg <= 1'b0;
            rd_tog_reg <= 1'b0;
        end else begin
            if (wr_byte_valid_i) begin
                prev_reg <= stage_reg;
                wr_tog_reg <= ~wr_tog_reg;
                if (!wr_tog_reg) begin // [RL23]
                    stage_reg.hi <= wr_byte_i;
                    stage_reg.has_hi <= 1'b1;
                end else begin
                    stage_reg.lo <= wr_byte_i;
                    stage_reg.has_lo <= 1'b1;
                end
            end
            if (rd_req_i) begin
                rd_tog_reg <= ~rd_tog_reg; // [RL24]
            end
        end
    end

    // commit decode
    always_comb begin
        use_stg = cfg_reg.pec ? prev_reg : stage_reg; // [RL21]
        commit = msg_stop_i && !bus_reset_reg && use_stg.has_hi &&
                 (!cfg_reg.pec || crc_reg == 8'h00); // [RL21]
        if (ptr_reg == tscac_pkg::PTR_CFG) begin
            cur_word = cfg_reg;
        end else if (ptr_reg == tscac_pkg::PTR_HYST) begin
            cur_word = hyst_reg;
        end else begin
            cur_word = os_reg;
        end
        wr_word = {use_stg.hi, use_stg.has_lo ? use_stg.lo : cur_word[7:0]}; // [RL23]
        wr_cfg = tscac_pkg::tscac_cfg_t'(wr_word);
        cfg_wr = commit && ptr_reg == tscac_pkg::PTR_CFG;
    end

    // writable registers; accepted in any mode
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_reg <= tscac_pkg::tscac_cfg_t'(tscac_pkg::CFG_RST); // [RL22]
            hyst_reg <= tscac_pkg::HYST_RST; // [RL22]
            os_reg <= tscac_pkg::OS_RST; // [RL22]
        end else if (commit) begin // [RL12]
            if (ptr_reg == tscac_pkg::PTR_CFG) begin
                cfg_reg <= tscac_pkg::tscac_cfg_t'(wr_word & tscac_pkg::CFG_WR_MASK);
            end else if (ptr_reg == tscac_pkg::PTR_HYST) begin
                hyst_reg <= wr_word;
            end else if (ptr_reg == tscac_pkg::PTR_OS) begin
                os_reg <= wr_word;
            end
        end
    end

    // conversion timing
    always_comb begin
        conv_len = 32'((CONV10_CYC * tscac_pkg::CONV_QTR[cfg_reg.res]) /
                       tscac_pkg::CONV_QTR_DIV); // [RL9] [RL10]
        period = 32'(RATE_BASE_CYC * tscac_pkg::RATE_MULT[cfg_reg.rate]); // [RL7]
        // at-or-past, so a shorter setting written mid-count cannot skip the end
        done = state_reg == tscac_pkg::ST_CONV && t_reg >= conv_len - 32'h0000_0001;
        wrap = !cfg_reg.sd && state_reg != tscac_pkg::ST_IDLE &&
               t_reg >= period - 32'h0000_0001; // [RL7]
        sd_enter = (done && cfg_reg.sd && !shot_reg) ||
                   (state_reg == tscac_pkg::ST_WAIT && cfg_reg.sd);
    end

    // conversion sequencer
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= tscac_pkg::ST_CONV;
            t_reg <= 32'h0000_0000;
            shot_reg <= 1'b0;
        end else if (cfg_wr && cfg_reg.sd && !wr_cfg.sd) begin
            state_reg <= tscac_pkg::ST_CONV; // [RL13]
            t_reg <= 32'h0000_0000;
            shot_reg <= 1'b0;
        end else if (cfg_wr && cfg_reg.sd && wr_cfg.sd && wr_cfg.one &&
                     state_reg == tscac_pkg::ST_IDLE) begin
            state_reg <= tscac_pkg::ST_CONV; // [RL2]
            t_reg <= 32'h0000_0000;
            shot_reg <= 1'b1;
        end else begin
            case (state_reg)
                tscac_pkg::ST_CONV: begin
                    if (done) begin
                        shot_reg <= 1'b0; // [RL2]
                        if (cfg_reg.sd) begin
                            state_reg <= tscac_pkg::ST_IDLE; // [RL11] [RL2]
                        end else if (wrap) begin
                            t_reg <= 32'h0000_0000;
                        end else begin
                            state_reg <= tscac_pkg::ST_WAIT; // [RL8]
                            t_reg <= t_reg + 32'h0000_0001;
                        end
                    end else if (wrap) begin
                        t_reg <= 32'h0000_0000;
                    end else begin
                        t_reg <= t_reg + 32'h0000_0001;
                    end
                end
                tscac_pkg::ST_WAIT: begin
                    if (cfg_reg.sd) begin
                        state_reg <= tscac_pkg::ST_IDLE;
                    end else if (wrap) begin
                        state_reg <= tscac_pkg::ST_CONV; // [RL7]
                        t_reg <= 32'h0000_0000;
                    end else begin
                        t_reg <= t_reg + 32'h0000_0001;
                    end
                end
                default: begin
                    t_reg <= 32'h0000_0000;
                end
            endcase
        end
    end

    // result formatting and threshold compare
    always_comb begin
        if (temp_raw_i > tscac_pkg::NORM_MAX) begin
            t_clamp = tscac_pkg::NORM_MAX;
        end else if (temp_raw_i < tscac_pkg::NORM_MIN) begin
            t_clamp = tscac_pkg::NORM_MIN;
        end else begin
            t_clamp = temp_raw_i;
        end
        lsb = (cfg_reg.fmt ? tscac_pkg::LSB_EXT : tscac_pkg::LSB_NORMAL) -
              tscac_pkg::RES_FRAC[cfg_reg.res]; // [RL9]
        mask = ~((16'h0001 << lsb) - 16'h0001);
        res_next = (cfg_reg.fmt ? {temp_raw_i, 3'h0} : {t_clamp[11:0], 4'h0}) & mask; // [RL4]
        eff_hyst = ($signed(hyst_reg) > $signed(os_reg)) ? os_reg : hyst_reg; // [RL1] [RL6]
        over = $signed(res_next) > $signed(os_reg); // [RL26]
        under = $signed(res_next) < $signed(eff_hyst);
        over_q = over && ({1'b0, fault_cnt_reg} + 4'h1 >=
                          {1'b0, tscac_pkg::FAULT_NEED[cfg_reg.fault]}); // [RL14]
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            result_reg <= tscac_pkg::TEMP_RST;
        end else if (done) begin
            result_reg <= res_next; // [RL25] [RL5]
        end
    end

    // overtemperature flag and fault queue
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            fault_cnt_reg <= 3'h0;
            flag_reg <= 1'b0;
            arm_low_reg <= 1'b0;
        end else begin
            if (sd_enter || (done && !over)) begin
                fault_cnt_reg <= 3'h0; // [RL26]
            end else if (done && fault_cnt_reg != tscac_pkg::FAULT_SAT) begin
                fault_cnt_reg <= fault_cnt_reg + 3'h1;
            end
            if (done && !cfg_reg.intr && over_q) begin
                flag_reg <= 1'b1; // [RL17]
            end else if (done && cfg_reg.intr && !arm_low_reg && over_q) begin
                flag_reg <= 1'b1; // [RL18]
                arm_low_reg <= 1'b1; // [RL19]
            end else if (done && cfg_reg.intr && arm_low_reg && under) begin
                flag_reg <= 1'b1; // [RL19] [RL15]
                arm_low_reg <= 1'b0;
            end else if (sd_enter) begin
                flag_reg <= 1'b0; // [RL17] [RL20]
                arm_low_reg <= 1'b0;
            end else if (done && !cfg_reg.intr && under) begin
                flag_reg <= 1'b0; // [RL15] [RL17]
            end else if (rd_req_i && cfg_reg.intr) begin
                flag_reg <= 1'b0; // [RL18]
            end
        end
    end

    // read path
    always_comb begin
        cfg_rd = cfg_reg;
        cfg_rd.ot = flag_reg; // [RL16]
        cfg_rd.one = shot_reg; // [RL2]
        if (ptr_reg == tscac_pkg::PTR_TEMP) begin
            rd_word = result_reg;
        end else if (ptr_reg == tscac_pkg::PTR_CFG) begin
            rd_word = cfg_rd;
        end else if (ptr_reg == tscac_pkg::PTR_HYST) begin
            rd_word = hyst_reg;
        end else if (ptr_reg == tscac_pkg::PTR_OS) begin
            rd_word = os_reg;
        end else begin
            rd_word = 16'h0000;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_data_reg <= 8'h00;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= rd_req_i;
            if (rd_req_i) begin
                rd_data_reg <= rd_tog_reg ? rd_word[7:0] : rd_word[15:8]; // [RL24]
            end
        end
    end

    assign rd_data_o = rd_data_reg;
    assign rd_valid_o = rd_valid_reg;
    assign pec_o = crc_reg;
    assign bus_reset_o = bus_reset_reg;
    assign conv_active_o = state_reg == tscac_pkg::ST_CONV;
    assign overtemp_o = flag_reg;
endmodule

/* tb/tscac_core_assertions.sv */
/*
 port checker for tscac_core, bound to every instance.
 assumes one clock domain with rst_i as its reset.
*/
`timescale 1ns/1ps
module tscac_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic msg_start_i,
    input wire logic msg_stop_i,
    input wire logic bus_byte_valid_i,
    input wire logic rd_req_i,
    input wire logic [7:0] rd_data_o,
    input wire logic rd_valid_o,
    input wire logic [7:0] pec_o,
    input wire logic bus_reset_o,
    input wire logic conv_active_o,
    input wire logic overtemp_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_rd_answer: assert property (rd_req_i |=> rd_valid_o)
        else $error("read request not answered");
    a_rd_cause: assert property (rd_valid_o |-> $past(rd_req_i))
        else $error("read data without request");
    a_rd_hold: assert property (!rd_req_i |=> $stable(rd_data_o))
        else $error("read data moved without request");
    a_pec_clear: assert property (msg_start_i && !bus_byte_valid_i |=> pec_o == 8'h00)
        else $error("check byte not cleared at start");
    a_pec_hold: assert property (!msg_start_i && !bus_byte_valid_i && !bus_reset_o
        |=> $stable(pec_o))
        else $error("check byte moved without bus byte");
    a_tmo_pulse: assert property (bus_reset_o |=> !bus_reset_o)
        else $error("bus reset longer than one cycle");
    a_tmo_low: assert property ($rose(bus_reset_o) |-> !$past(scl_i, 6))
        else $error("bus reset while clock line high");
    a_ot_set_conv: assert property ($rose(overtemp_o) |-> $past(conv_active_o))
        else $error("flag set outside conversion end");
    a_ot_clr_cause: assert property ($fell(overtemp_o) |-> $past(conv_active_o)
        || $past(rd_req_i) || $past(rd_valid_o) || $past(msg_stop_i, 2))
        else $error("flag cleared without cause");
    a_conv_min: assert property ($rose(conv_active_o) |-> conv_active_o[*8])
        else $error("conversion too short");
    c_ot: cover property ($rose(overtemp_o));
    c_tmo: cover property (bus_reset_o);
    c_rd: cover property (rd_valid_o ##2 rd_valid_o);
endmodule
bind tscac_core tscac_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_i),
    .msg_start_i(msg_start_i), .msg_stop_i(msg_stop_i), .bus_byte_valid_i(bus_byte_valid_i),
    .rd_req_i(rd_req_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .pec_o(pec_o),
    .bus_reset_o(bus_reset_o), .conv_active_o(conv_active_o), .overtemp_o(overtemp_o));

/* tb/tscac_mst.sv */
/*
 byte-level bus master model driving the framing inputs.
 assumes inputs are sampled on clk_i rising edges.
*/
`timescale 1ns/1ps
module tscac_mst (
    input wire logic clk_i,
    input wire logic [7:0] rd_data_i,
    output logic scl_o,
    output logic start_o,
    output logic stop_o,
    output logic bv_o,
    output logic [7:0] b_o,
    output logic pw_o,
    output logic wv_o,
    output logic rq_o
);
    localparam logic [7:0] ADDR = 8'h90; // arbitrary bus address
    logic lo = 0;
    logic frm = 0;
    logic [7:0] crc = 8'h00;
    initial begin
        {start_o, stop_o, bv_o, pw_o, wv_o, rq_o, b_o} = '0;
        scl_o = 1'b1;
        forever #80 scl_o = lo ? 1'b0 : (frm ? ~scl_o : 1'b1);
    end
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] x;
        x = c ^ d;
        for (int i = 0; i < 8; i++) x = {x[6:0], 1'b0} ^ (x[7] ? 8'h07 : 8'h00);
        return x;
    endfunction
    // one cycle of pulses; idle byte lines toggle
    task automatic cyc(input logic [5:0] f, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        {start_o, stop_o, bv_o, pw_o, wv_o, rq_o} = f;
        b_o = f[3] ? d : ~b_o;
        crc = f[5] ? 8'h00 : (f[3] ? crc8(crc, d) : crc);
    endtask
    task automatic hdr(input logic [7:0] p);
        frm = 1;
        cyc(6'h20, 8'h00);
        cyc(6'h08, ADDR);
        cyc(6'h0c, p);
    endtask
    task automatic fin();
        cyc(6'h10, 8'h00);
        cyc(6'h00, 8'h00);
        frm = 0;
    endtask
    // check byte appended when pe, spoilt when bad
    task automatic wr(input logic [7:0] p, input logic [23:0] d, input int n,
                      input logic pe = 0, input logic bad = 0);
        hdr(p);
        for (int i = 0; i < n; i++) cyc(6'h0a, d[23-8*i-:8]);
        if (pe) cyc(6'h0a, crc ^ {7'h00, bad});
        fin();
    endtask
    task automatic rd(input logic [7:0] p, output logic [15:0] v);
        hdr(p);
        cyc(6'h08, ADDR | 8'h01);
        cyc(6'h01, 8'h00);
        cyc(6'h00, 8'h00);
        v[15:8] = rd_data_i;
        cyc(6'h01, 8'h00);
        cyc(6'h00, 8'h00);
        v[7:0] = rd_data_i;
        fin();
    endtask
    task automatic scl_low(input int n);
        lo = 1;
        repeat (n) @(posedge clk_i);
        lo = 0;
        #200;
    endtask
endmodule

/* tb/tb_top.sv */
/*
 self-checking bench for tscac_core with a bus master model.
 assumes short timing parameters; inputs other than scl_i change 1 ns after clk_i rises.
*/
`timescale 1ns/1ps
module tb_top;
    logic clk_i = 0;
    logic rst_i = 1;
    logic signed [12:0] raw = 0;
    logic [7:0] b, rdd, pec;
    logic scl, st, sp, bv, pw, wv, rq, rdv, brst, act, ot, act_q;
    logic [15:0] v, ex;
    logic [15:0] por [5] = '{16'h0000, 16'h0040, 16'h4b00, 16'h5000, 16'h0000};
    int miscompares, checks, n_done, n_tmo, n_rv, cyc_n, t_last, per, hi_len, len, t;
    initial forever #10 clk_i = ~clk_i;
    tscac_core #(.TIMEOUT_CYC(50), .CONV10_CYC(40), .RATE_BASE_CYC(20)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .msg_start_i(st), .msg_stop_i(sp),
        .bus_byte_valid_i(bv), .bus_byte_i(b), .ptr_wr_i(pw), .ptr_i(b), .wr_byte_valid_i(wv),
        .wr_byte_i(b), .rd_req_i(rq), .temp_raw_i(raw), .rd_data_o(rdd), .rd_valid_o(rdv),
        .pec_o(pec), .bus_reset_o(brst), .conv_active_o(act), .overtemp_o(ot));
    tscac_mst u_mst (.clk_i(clk_i), .rd_data_i(rdd), .scl_o(scl), .start_o(st), .stop_o(sp),
        .bv_o(bv), .b_o(b), .pw_o(pw), .wv_o(wv), .rq_o(rq));
    always @(posedge clk_i) begin
        cyc_n++;
        act_q <= act;
        hi_len <= act ? hi_len + 1 : 0;
        if (brst) n_tmo++;
        if (rdv) n_rv++;
        if (act_q && !act) begin
            n_done++;
            per = cyc_n - t_last;
            t_last = cyc_n;
            len = hi_len;
        end
    end
    task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task rchk(input string nm, input logic [7:0] p, input logic [15:0] e);
        int k;
        k = n_rv;
        u_mst.rd(p, v);
        chk(nm, v, e);
        chk("rd_valid", 16'(n_rv - k), 16'h0002);
    endtask
    task wc(input logic [15:0] c);
        u_mst.wr(8'h01, {c, 8'h00}, 2);
    endtask
    task wdone(input int n);
        int k;
        k = n_done + n;
        repeat (3000) if (n_done < k) @(posedge clk_i);
        #1;
        chk("conv_done", 16'(n_done >= k), 16'h0001);
    endtask
    function automatic logic [15:0] exp_t(input logic signed [12:0] r, input logic f,
                                          input logic [1:0] s);
        logic signed [15:0] x;
        int sh;
        sh = 4 - tscac_pkg::RES_FRAC[s];
        x = r;
        if (!f && x > 2047) x = 2047;
        if (!f && x < -2048) x = -2048;
        x = (x >>> sh) <<< sh;
        return f ? x <<< 3 : x <<< 4;
    endfunction
    task give_verdict();
        if (miscompares == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #1_000_000;
        miscompares++;
        give_verdict();
    end
    initial begin
        v = 16'($urandom(15));
        repeat (6) @(posedge clk_i);
        #1 rst_i = 0;
        for (int i = 0; i < 5; i++) rchk("por", i[7:0], por[i]);
        ex = 16'($urandom);
        u_mst.wr(8'h02, {ex, 8'h00}, 2);
        chk("crc", 16'(pec), 16'(u_mst.crc));
        rchk("hyst", 8'h02, ex);
        u_mst.wr(8'h02, 24'ha5_0000, 1);
        rchk("hyst", 8'h02, {8'ha5, ex[7:0]});
        u_mst.wr(8'h02, 24'h12_3456, 3);
        rchk("hyst", 8'h02, 16'h5634);
        u_mst.wr(8'h00, 24'hff_ff00, 2);
        rchk("temp", 8'h00, 16'h0000);
        wc(16'h0048);
        u_mst.wr(8'h02, 24'h11_1100, 2, 1, 1);
        rchk("hyst", 8'h02, 16'h5634);
        u_mst.wr(8'h02, 24'h11_1100, 2, 1, 0);
        chk("crc", 16'(pec), 16'h0000);
        rchk("hyst", 8'h02, 16'h1111);
        u_mst.wr(8'h01, 24'h00_4000, 2, 1, 0);
        ex = 16'h0000;
        for (int i = 0; i < 8; i++) begin
            wdone(1);
            raw = 13'($urandom_range(3200)) - 13'd800;
            wc({8'h00, i[2], i[1:0], 5'h00});
            rchk("temp_old", 8'h00, ex);
            wdone(1);
            ex = exp_t(raw, i[2], i[1:0]);
            rchk("temp", 8'h00, ex);
            chk("conv_len", 16'(len), 16'(40 * tscac_pkg::CONV_QTR[i[1:0]] / 4));
        end
        for (int r = 0; r < 4; r++) begin
            wc({13'h0000, r[1:0], 1'b0});
            wdone(3);
            chk("period", 16'(per), 16'(20 * tscac_pkg::RATE_MULT[r]));
        end
        wc(16'h0060);
        wdone(1);
        raw = 13'sd400;
        repeat (700) if (!act) @(posedge clk_i);
        #2;
        wc(16'h0160);
        wdone(1);
        rchk("temp", 8'h00, exp_t(raw, 1'b0, 2'd3));
        t = n_done;
        wc(16'h0161);
        rchk("cfg", 8'h01, 16'h0161);
        wdone(1);
        rchk("cfg", 8'h01, 16'h0160);
        repeat (800) @(posedge clk_i);
        chk("sd_idle", 16'(n_done - t), 16'h0001);
        u_mst.wr(8'h03, 24'h19_0000, 2);
        u_mst.wr(8'h02, 24'h14_0000, 2);
        raw = 13'sd160;
        wc(16'h0806);
        chk("conv_start", 16'(act), 16'h0001);
        wdone(2);
        chk("ot", 16'(ot), 16'h0000);
        raw = 13'sd480;
        wdone(1);
        chk("ot", 16'(ot), 16'h0000);
        wdone(1);
        chk("ot", 16'(ot), 16'h0001);
        u_mst.wr(8'h02, 24'h30_0000, 2);
        wdone(2);
        rchk("cfg", 8'h01, 16'h8806);
        raw = 13'sd400;
        wdone(1);
        chk("ot", 16'(ot), 16'h0001);
        raw = 13'sd160;
        wdone(1);
        chk("ot", 16'(ot), 16'h0000);
        wc(16'h0206);
        raw = 13'sd480;
        wdone(1);
        chk("ot", 16'(ot), 16'h0001);
        rchk("limit", 8'h03, 16'h1900);
        chk("ot", 16'(ot), 16'h0000);
        wdone(2);
        chk("ot", 16'(ot), 16'h0000);
        raw = 13'sd160;
        wdone(1);
        chk("ot", 16'(ot), 16'h0001);
        wc(16'h0306);
        #600;
        chk("ot", 16'(ot), 16'h0000);
        t = n_tmo;
        u_mst.scl_low(150);
        chk("tmo", 16'(n_tmo - t), 16'h0001);
        wc(16'h0316);
        t = n_tmo;
        u_mst.scl_low(150);
        chk("tmo", 16'(n_tmo - t), 16'h0000);
        give_verdict();
    end
endmodule
